// ---- bench/sensor_matrix_scanner_bench.sv ----
// self-checking bench for the sensor matrix scanner
module sensor_matrix_scanner_bench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [63:0] contacts;
        logic        ex;
    } smsc_row_t;

    logic        clk = 1'b0, srst = 1'b1, scan_req = 1'b0, addr_only = 1'b0, rx_ready = 1'b0;
    logic        tx_valid = 1'b0, external_irq_high = 1'b1, external_irq_low = 1'b1, irq_high_ack = 1'b0;
    logic [11:0] actuator_cmd = 12'h000;
    logic [8:0]  tx_word = 9'h000;
    logic [63:0] contacts = 64'h0;
    logic [7:0]  column_drive_port, column_strobe_n, row_return_port;
    logic [2:0]  column_code;
    logic        row_port_busy, scan_busy, scan_done, example_actuator_out, serial_txd;
    logic        rx_valid, tx_ready, irq_service_high, irq_service_low;
    logic [63:0] cur_map, prev_map, change_map, old;
    logic [11:0] actuator_out;
    logic [8:0]  rx_word;
    wire         serial_rxd = serial_txd;
    int          n_errors = 0, samples_checked = 0, cycles = 0;
    smsc_row_t   rows [7] = '{
        '{64'h0000_0000_0000_0000, 1'b0}, '{64'h0000_0004_0080_1000, 1'b1},
        '{64'h0000_2004_0080_1000, 1'b0}, '{64'h0100_0004_0080_1000, 1'b0},
        '{64'hffff_ffff_ffff_ffff, 1'b0}, '{64'h0000_0004_0080_1000, 1'b1},
        '{64'h8421_1248_a55a_3cc3, 1'b0}};

    smsc_scanner #(.FIFO_DEPTH(2)) uut (
        .clk, .srst, .scan_req, .column_drive_port, .column_strobe_n, .column_code, .row_port_busy,
        .row_return_port, .scan_busy, .scan_done, .cur_map, .prev_map, .change_map, .actuator_cmd,
        .actuator_out, .example_actuator_out, .serial_rxd, .serial_txd, .addr_only, .rx_word, .rx_valid,
        .rx_ready, .tx_word, .tx_valid, .tx_ready, .external_irq_high, .external_irq_low, .irq_high_ack,
        .irq_service_high, .irq_service_low
    );

    smsc_matrix_model matrix (
        .column_drive_port(column_drive_port),
        .contacts         (contacts),
        .row_return_port  (row_return_port)
    );

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic final_report();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic check_vec(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_vec

    // scan_req held into column 2 to show it is ignored while busy
    task automatic run_scan(input logic [63:0] pat, input logic [63:0] prev, input logic ex);
        contacts = pat;
        scan_req = 1'b1;
        @(posedge clk);
        @(negedge clk);
        for (int k = 0; k < 8; k++) begin
            repeat ((k == 0) ? 3 : 5) @(negedge clk);
            if (k == 2) scan_req = 1'b0;
            check_vec(column_drive_port, 8'h80 >> k);
            check_vec(column_strobe_n, 8'(~(8'h80 >> k)));
            check_vec(column_code, k);
            check_vec({row_port_busy, scan_busy, scan_done}, 3'h6);
        end
        repeat (2) @(negedge clk);
        check_vec({scan_done, scan_busy, row_port_busy, column_drive_port, column_strobe_n}, 19'h400ff);
        check_vec(cur_map, pat);
        check_vec(prev_map, prev);
        @(negedge clk);
        check_vec(change_map, pat ^ prev);
        check_vec({scan_busy, scan_done, example_actuator_out}, ex);
    endtask : run_scan

    task automatic send(input logic [8:0] w);
        tx_word = w;
        tx_valid = 1'b1;
        for (int i = 0; i < 20 && tx_ready !== 1'b1; i++) @(posedge clk);
        @(posedge clk);
        @(negedge clk);
        tx_valid = 1'b0;
        for (int i = 0; i < 7000 && tx_ready !== 1'b1; i++) @(negedge clk);
        repeat (600) @(negedge clk);
    endtask : send

    task automatic pop(input logic [8:0] exp);
        logic [8:0] got;
        got = 9'h000;
        rx_ready = 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            if (rx_valid === 1'b1) begin
                got = rx_word;
                break;
            end
        end
        @(negedge clk);
        rx_ready = 1'b0;
        check_vec(got, exp);
    endtask : pop

    initial begin
        repeat (12) @(negedge clk);
        check_vec({column_drive_port, column_strobe_n, column_code, row_port_busy, scan_busy, scan_done,
                   serial_txd, tx_ready, rx_valid, irq_service_high, irq_service_low, actuator_out},
                  {8'h00, 8'hff, 3'h0, 3'h0, 2'h3, 3'h0, 12'h000});
        check_vec(cur_map | prev_map | change_map, 64'h0);
        srst = 1'b0;
        old = 64'h0;
        foreach (rows[i]) begin
            run_scan(rows[i].contacts, old, rows[i].ex);
            old = rows[i].contacts;
        end
        for (int i = 0; i < 12; i++) begin
            actuator_cmd = 12'h001 << i;
            @(negedge clk);
            check_vec(actuator_out, 12'h001 << i);
        end
        external_irq_high = 1'b0;
        repeat (6) @(negedge clk);
        external_irq_high = 1'b1;
        external_irq_low = 1'b0;
        repeat (5) @(negedge clk);
        check_vec({irq_service_high, irq_service_low}, 2'h2);
        irq_high_ack = 1'b1;
        @(negedge clk);
        irq_high_ack = 1'b0;
        repeat (5) @(negedge clk);
        check_vec({irq_service_high, irq_service_low}, 2'h1);
        external_irq_low = 1'b1;
        repeat (5) @(negedge clk);
        check_vec({irq_service_high, irq_service_low}, 2'h0);
        addr_only = 1'b1;
        send(9'h055);
        for (int i = 1; i < 5; i++) send(9'h100 | i);
        for (int i = 1; i < 4; i++) pop(9'h100 | i);
        repeat (20) @(negedge clk);
        check_vec(rx_valid, 1'b0);
        addr_only = 1'b0;
        send(9'h0aa);
        pop(9'h0aa);
        final_report();
    end
endmodule : sensor_matrix_scanner_bench

// ---- bench/smsc_matrix_model.sv ----
// diode switch matrix model: closed contacts drive rows high, open rows pulled low
module smsc_matrix_model (
    input  wire logic [7:0]  column_drive_port,
    input  wire logic [63:0] contacts,
    output logic      [7:0]  row_return_port
);
    timeunit 1ns;
    timeprecision 1ps;

    always_comb begin
        row_return_port = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (column_drive_port[7 - k]) begin
                row_return_port = row_return_port | contacts[8 * k +: 8];
            end
        end
    end
endmodule : smsc_matrix_model

// ---- pkg/smsc_pkg.sv ----
// constants, states and timing for the sensor matrix scanner
// What this block does
// R1 - sixty-four inputs form eight columns by eight rows, one column at a time
// R2 - drive each column in turn and capture all eight row returns meanwhile
// R3 - basic variant: eight separate unencoded active-high column strobes
// R4 - start at strobe 80h, rotate right per column, stop when bit seven returns
// R5 - matrix drives a row high for a closed contact, low when open
// R6 - current state kept as eight bytes, one per column, at first map base
// R7 - previous map at second base; old current byte moves there on replacement
// R8 - both maps positive logic: one means closed or conducting
// R9 - sensor index equals absolute bit address inside the map region
// R10 - current and previous maps compared bit by bit to flag transitions
// R11 - buffered variant: active-low strobes; row port free between scans
// R12 - multiplexed variant: encoded column number on three lines
// R13 - host link is a nine-bit asynchronous serial port near 17000 bytes per second
// R14 - receiver mode accepting only bytes whose ninth address bit is set
// R15 - high interrupt falling-edge and high priority; low one low-level, low priority
// R16 - twelve actuator outputs driven at logic levels
// R17 - example output true when 12, 23, 34 closed and 45, 56 open
// R18 - column strobe held stable until its row sample is captured
package smsc_pkg;
    localparam int           COLS          = 8;
    localparam int           ROWS          = 8;
    localparam logic [7:0]   STROBE_FIRST  = 8'h80;
    localparam logic [7:0]   BIT_AREA_BASE = 8'h20;
    localparam logic [7:0]   CUR_MAP_BASE  = 8'h20;
    localparam logic [7:0]   PREV_MAP_BASE = 8'h28;
    localparam int           CUR_BIT0      = (CUR_MAP_BASE - BIT_AREA_BASE) * 8;
    localparam int           PREV_BIT0     = (PREV_MAP_BASE - BIT_AREA_BASE) * 8;
    localparam int           SETTLE_CYCLES = 4;
    localparam int           ACT_COUNT     = 12;
    localparam int           EX_ON_A       = 12;
    localparam int           EX_ON_B       = 23;
    localparam int           EX_ON_C       = 34;
    localparam int           EX_OFF_A      = 45;
    localparam int           EX_OFF_B      = 56;
    localparam int           CLK_HZ        = 100_000_000;
    localparam int           BYTE_RATE     = 17_000;
    localparam int           FRAME_BITS    = 11;
    localparam int           WORD_BITS     = 9;
    localparam int           BIT_CYCLES    = CLK_HZ / (BYTE_RATE * FRAME_BITS);
    localparam int           HALF_CYCLES   = BIT_CYCLES / 2;
    localparam int           FIFO_DEPTH    = 16;

    typedef enum logic [1:0] {
        SC_IDLE    = 2'b00,
        SC_SETTLE  = 2'b01,
        SC_CAPTURE = 2'b10
    } smsc_scan_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } smsc_rx_t;
endpackage : smsc_pkg

// ---- src/smsc_scanner.sv ----
// sensor matrix scanner with serial link, interrupts, actuators and receive fifo

module smsc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid && in_ready;
    wire              load = (count != '0) && (!out_valid || out_ready);

    assign in_ready = (count != (AW+1)'(DEPTH));

    // storage and pointers
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (load) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // registered output stage
    always_ff @(posedge clk) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule : smsc_fifo

module smsc_scanner #(
    parameter int FIFO_DEPTH = smsc_pkg::FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         scan_req,
    output logic      [7:0]   column_drive_port,
    output logic      [7:0]   column_strobe_n,
    output logic      [2:0]   column_code,
    output logic              row_port_busy,
    input  wire logic [7:0]   row_return_port,
    output logic              scan_busy,
    output logic              scan_done,
    output logic      [63:0]  cur_map,
    output logic      [63:0]  prev_map,
    output logic      [63:0]  change_map,
    input  wire logic [11:0]  actuator_cmd,
    output logic      [11:0]  actuator_out,
    output logic              example_actuator_out,
    input  wire logic         serial_rxd,
    output logic              serial_txd,
    input  wire logic         addr_only,
    output logic      [8:0]   rx_word,
    output logic              rx_valid,
    input  wire logic         rx_ready,
    input  wire logic [8:0]   tx_word,
    input  wire logic         tx_valid,
    output logic              tx_ready,
    input  wire logic         external_irq_high,
    input  wire logic         external_irq_low,
    input  wire logic         irq_high_ack,
    output logic              irq_service_high,
    output logic              irq_service_low
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // pin synchronisers
    logic [7:0] row_s1;
    logic [7:0] row_s2;
    logic       rxd_s1;
    logic       rxd_s2;
    logic       hi_s1;
    logic       hi_s2;
    logic       hi_s3;
    logic       lo_s1;
    logic       lo_s2;

    always_ff @(posedge clk) begin
        if (srst) begin
            row_s1 <= '0;
            row_s2 <= '0;
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            hi_s1  <= 1'b1;
            hi_s2  <= 1'b1;
            hi_s3  <= 1'b1;
            lo_s1  <= 1'b1;
            lo_s2  <= 1'b1;
        end else begin
            row_s1 <= row_return_port;
            row_s2 <= row_s1;
            rxd_s1 <= serial_rxd;
            rxd_s2 <= rxd_s1;
            hi_s1  <= external_irq_high;
            hi_s2  <= hi_s1;
            hi_s3  <= hi_s2;
            lo_s1  <= external_irq_low;
            lo_s2  <= lo_s1;
        end
    end

    // ---------------- matrix scan ----------------
    smsc_pkg::smsc_scan_t state;
    logic [7:0] work_accumulator;
    logic [2:0] col;
    logic [2:0] settle_cnt;

    wire [7:0] rotated   = {work_accumulator[0], work_accumulator[7:1]};    // see R4
    wire       wrap      = rotated[7];                                      // see R4
    wire       start     = (state == smsc_pkg::SC_IDLE) && scan_req;
    wire       settled   = (settle_cnt == 3'(smsc_pkg::SETTLE_CYCLES - 1));
    wire       capture   = (state == smsc_pkg::SC_CAPTURE);
    wire [5:0] byte_bit  = {col, 3'b000};                                  // see R1 R9
    wire [7:0] old_byte  = cur_map[byte_bit +: 8];
    wire       ex_next   = cur_map[smsc_pkg::EX_ON_A] && cur_map[smsc_pkg::EX_ON_B]
                        && cur_map[smsc_pkg::EX_ON_C] && !cur_map[smsc_pkg::EX_OFF_A]
                        && !cur_map[smsc_pkg::EX_OFF_B];                  // see R17

    assign column_drive_port = work_accumulator;                            // see R3

    always_ff @(posedge clk) begin
        if (srst) begin
            state            <= smsc_pkg::SC_IDLE;
            work_accumulator <= '0;
            column_strobe_n  <= 8'hff;
            column_code      <= '0;
            col              <= '0;
            settle_cnt       <= '0;
            scan_busy        <= 1'b0;
            row_port_busy    <= 1'b0;
            scan_done        <= 1'b0;
        end else begin
            scan_done <= 1'b0;
            case (state)
                smsc_pkg::SC_IDLE: begin
                    if (scan_req) begin
                        work_accumulator <= smsc_pkg::STROBE_FIRST;         // see R4
                        column_strobe_n  <= ~smsc_pkg::STROBE_FIRST;        // see R11
                        column_code      <= '0;                             // see R12
                        col              <= '0;
                        settle_cnt       <= '0;
                        scan_busy        <= 1'b1;
                        row_port_busy    <= 1'b1;
                        state            <= smsc_pkg::SC_SETTLE;
                    end
                end
                smsc_pkg::SC_SETTLE: begin
                    settle_cnt <= settle_cnt + 3'd1;                        // see R18
                    if (settled) begin
                        state <= smsc_pkg::SC_CAPTURE;
                    end
                end
                smsc_pkg::SC_CAPTURE: begin
                    settle_cnt <= '0;
                    if (wrap) begin
                        work_accumulator <= '0;                             // see R4
                        column_strobe_n  <= 8'hff;                          // see R11
                        scan_busy        <= 1'b0;
                        row_port_busy    <= 1'b0;
                        scan_done        <= 1'b1;
                        state            <= smsc_pkg::SC_IDLE;
                    end else begin
                        work_accumulator <= rotated;                        // see R2
                        column_strobe_n  <= ~rotated;
                        column_code      <= col + 3'd1;                     // see R12
                        col              <= col + 3'd1;
                        state            <= smsc_pkg::SC_SETTLE;
                    end
                end
                default: begin
                    state <= smsc_pkg::SC_IDLE;
                end
            endcase
        end
    end

    // bit maps: sensor n sits at bit n, column k fills bits 8k..8k+7
    always_ff @(posedge clk) begin
        if (srst) begin
            cur_map              <= '0;
            prev_map             <= '0;
            change_map           <= '0;
            example_actuator_out <= 1'b0;
            actuator_out         <= '0;
        end else begin
            if (capture) begin
                cur_map[byte_bit +: 8]  <= row_s2;                          // see R6 R8 R9
                prev_map[byte_bit +: 8] <= old_byte;                        // see R7
            end
            change_map           <= cur_map ^ prev_map;                     // see R10
            example_actuator_out <= ex_next;                                // see R17
            actuator_out         <= actuator_cmd;                           // see R16
        end
    end

    // ---------------- interrupts ----------------
    wire hi_fall   = hi_s3 && !hi_s2;                                       // see R15
    wire next_high = hi_fall || (irq_service_high && !irq_high_ack);

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_service_high <= 1'b0;
            irq_service_low  <= 1'b0;
        end else begin
            irq_service_high <= next_high;                                  // see R15
            irq_service_low  <= !lo_s2 && !next_high;                       // see R15
        end
    end

    // ---------------- serial receive ----------------
    smsc_pkg::smsc_rx_t rx_state;
    logic [9:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [8:0] rx_shift;
    logic       fifo_in_ready;

    wire rx_bit_end = (rx_cnt == 10'(smsc_pkg::BIT_CYCLES - 1));
    wire rx_push    = (rx_state == smsc_pkg::RX_STOP) && rx_bit_end && rxd_s2
                   && (!addr_only || rx_shift[8]);                          // see R14

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_state <= smsc_pkg::RX_IDLE;
            rx_cnt   <= '0;
            rx_bits  <= '0;
            rx_shift <= '0;
        end else begin
            rx_cnt <= rx_cnt + 10'd1;
            case (rx_state)
                smsc_pkg::RX_IDLE: begin
                    rx_cnt <= '0;
                    if (!rxd_s2) begin
                        rx_state <= smsc_pkg::RX_START;
                    end
                end
                smsc_pkg::RX_START: begin
                    if (rx_cnt == 10'(smsc_pkg::HALF_CYCLES - 1)) begin
                        rx_cnt   <= '0;
                        rx_bits  <= '0;
                        rx_state <= rxd_s2 ? smsc_pkg::RX_IDLE : smsc_pkg::RX_DATA;
                    end
                end
                smsc_pkg::RX_DATA: begin
                    if (rx_bit_end) begin
                        rx_cnt   <= '0;
                        rx_shift <= {rxd_s2, rx_shift[8:1]};                // see R13
                        rx_bits  <= rx_bits + 4'd1;
                        if (rx_bits == 4'(smsc_pkg::WORD_BITS - 1)) begin
                            rx_state <= smsc_pkg::RX_STOP;
                        end
                    end
                end
                smsc_pkg::RX_STOP: begin
                    if (rx_bit_end) begin
                        rx_state <= smsc_pkg::RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= smsc_pkg::RX_IDLE;
                end
            endcase
        end
    end

    smsc_fifo #(
        .WIDTH (smsc_pkg::WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (rx_push),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_shift),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_word)
    );

    // ---------------- serial transmit ----------------
    logic [9:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [9:0] tx_shift;

    wire tx_take    = tx_valid && tx_ready;
    wire tx_bit_end = (tx_cnt == 10'(smsc_pkg::BIT_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_ready   <= 1'b1;
            serial_txd <= 1'b1;
            tx_cnt     <= '0;
            tx_bits    <= '0;
            tx_shift   <= '0;
        end else if (tx_take) begin
            tx_ready   <= 1'b0;
            serial_txd <= 1'b0;                                             // see R13
            tx_shift   <= {1'b1, tx_word};
            tx_cnt     <= '0;
            tx_bits    <= '0;
        end else if (!tx_ready) begin
            tx_cnt <= tx_cnt + 10'd1;
            if (tx_bit_end) begin
                tx_cnt <= '0;
                if (tx_bits == 4'(smsc_pkg::FRAME_BITS - 1)) begin
                    tx_ready <= 1'b1;
                end else begin
                    serial_txd <= tx_shift[0];
                    tx_shift   <= {1'b1, tx_shift[9:1]};
                    tx_bits    <= tx_bits + 4'd1;
                end
            end
        end
    end

    // ---------------- checks ----------------
    logic [2:0] chk_col;
    logic [7:0] chk_row;
    logic [7:0] chk_old;
    logic       chk_seen;

    always_ff @(posedge clk) begin
        if (srst) begin
            chk_seen <= 1'b0;
            chk_col  <= '0;
            chk_row  <= '0;
            chk_old  <= '0;
        end else begin
            chk_seen <= capture;
            chk_col  <= col;
            chk_row  <= row_s2;
            chk_old  <= old_byte;
        end
    end

    strobe_onehot_a: assert property (scan_busy |-> $onehot(column_drive_port))     // see R1
        else $error("column strobe not one-hot during scan");
    strobe_first_a: assert property (start |=> column_drive_port == 8'h80)          // see R4
        else $error("scan did not start at top column");
    strobe_rotate_a: assert property (capture && !wrap |=>                          // see R4
        column_drive_port == {$past(column_drive_port[0]), $past(column_drive_port[7:1])})
        else $error("strobe did not rotate right");
    strobe_hold_a: assert property (state == smsc_pkg::SC_SETTLE |=> $stable(column_drive_port)) // see R18
        else $error("strobe changed before capture");
    cur_store_a: assert property (chk_seen |-> cur_map[{chk_col, 3'b000} +: 8] == chk_row) // see R6
        else $error("row sample not stored in current map");
    prev_store_a: assert property (chk_seen |-> prev_map[{chk_col, 3'b000} +: 8] == chk_old) // see R7
        else $error("old byte not moved to previous map");
    strobe_low_a: assert property (column_strobe_n == ~column_drive_port)          // see R11
        else $error("active-low strobe out of step");
    scan_length_a: assert property (start |-> ##41 scan_done)                      // see R2
        else $error("scan did not finish after eight columns");
    code_match_a: assert property (scan_busy |-> column_drive_port == (8'h80 >> column_code)) // see R12
        else $error("encoded column does not match strobe");
    example_out_a: assert property (##1 example_actuator_out ==                    // see R17
        $past(ex_next))
        else $error("example actuator output wrong");
    irq_prio_a: assert property (!(irq_service_high && irq_service_low))           // see R15
        else $error("both interrupt levels serviced together");
    addr_filter_a: assert property (rx_push && addr_only |-> rx_shift[8])          // see R14
        else $error("data byte accepted in address-only mode");
    tx_start_a: assert property (tx_take |=> !serial_txd && !tx_ready)             // see R13
        else $error("transmit start bit missing");
endmodule : smsc_scanner
